/* File: common/crm_pkg.sv */
package crm_pkg;
  // opcodes
  localparam logic [11:0] OP_OPTION_W = 12'h002;
  localparam logic [11:0] OP_MODE_W = 12'h043;
  localparam logic [7:0] OP_MODE_LIT_HI = 8'h05;
  localparam logic [7:0] OP_PORT_HI = 8'h00;
  localparam logic [3:0] PORT_FIRST = 4'h5;
  localparam logic [3:0] PORT_LAST = 4'h9;
  localparam logic [3:0] PORT_B_FIELD = 4'h6;
  localparam int NUM_PORTS = 5;
  localparam int NUM_CTRL = 7;
  // mode pointer values
  localparam logic [3:0] MODE_CMP_LO = 4'h8;
  localparam logic [3:0] MODE_IDX_TOP = 4'hf;
  localparam logic [3:0] MODE_IDX_LOW = 4'ha;
  localparam logic [3:0] MODE_XCHG_LO = 4'h9;
  localparam logic [2:0] IDX_DIR = 3'h0;
  localparam logic [2:0] IDX_XCHG = 3'h6;
  localparam logic [4:0] MODE_DIR_WRITE = 5'h1f;
  // reset values
  localparam logic [7:0] RST_W = 8'h00;
  localparam logic [4:0] RST_MODE = 5'h00;
  localparam logic [7:0] RST_OPTION = 8'hff;
  localparam logic [7:0] RST_CTRL = 8'hff;
  localparam logic [7:0] RST_CMP = 8'hff;
  // register map, byte addresses
  localparam logic [7:0] ADDR_W = 8'h00;
  localparam logic [7:0] ADDR_MODE = 8'h04;
  localparam logic [7:0] ADDR_OPTION = 8'h08;
  localparam logic [7:0] ADDR_CMP = 8'h0c;
  localparam logic [7:0] ADDR_CTRL_BASE = 8'h40;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    ACC_NONE, ACC_READ, ACC_WRITE, ACC_XCHG, ACC_CMP
  } crm_acc_e;

  typedef struct packed {
    crm_acc_e kind;
    logic [2:0] idx;
  } crm_acc_s;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } crm_axil_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } crm_axil_rsp_s;

  typedef logic [NUM_PORTS-1:0][NUM_CTRL-1:0][7:0] crm_ctrl_t;
endpackage

/* File: logic/crm_exec.sv */
// What this block does
// - opcode 002h copies W into option register, W and flags untouched.
// - option register holds counter interrupt, increment event, prescaler settings.
// - opcodes 005h..009h move data between W and port A..E control.
// - mode pointer picks control register and read, write or exchange.
// - port data register is never reached through control transfers.
// - each port has separate direction, pull-up, Schmitt and other registers.
// - mode 1Fh writes direction register; 1 is input, 0 output.
// - mode low nibble 8 selects comparator control through port B.
// - comparator access exchanges with W; 00h enables comparator and pin.
// - mode load from W takes low 4 or 5 bits, W unchanged.
`timescale 1ns/1ps
`default_nettype none
module crm_exec
  import crm_pkg::*;
#(
  parameter int MODE_W = 5
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // instruction fetch
  input wire logic i_instr_valid,
  input wire logic [11:0] i_instr,
  // register bus
  input wire crm_axil_req_s i_axi,
  output crm_axil_rsp_s o_axi,
  // core state
  output logic [7:0] o_w,
  output logic [4:0] o_mode,
  output logic [7:0] o_option,
  output logic [7:0] o_cmp_ctrl,
  output crm_ctrl_t o_port_ctrl,
  output logic o_exec
);

  // only the narrow and the wide pointer are served by the decode below
  if (MODE_W != 4 && MODE_W != 5) begin : g_mode_w_check
    $error("MODE_W must be 4 or 5");
  end

  typedef struct packed {
    logic [7:0] w;
    logic [4:0] mode;
    logic [7:0] option;
    logic [7:0] cmp;
    crm_ctrl_t ctrl;
    logic exec;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } crm_state_s;

  crm_state_s state_reg;
  crm_state_s state_next;

  // upper pointer bit exists only on the wide variant
  localparam logic [4:0] MODE_MASK = (MODE_W == 5) ? 5'h1f : 5'h0f;

  function automatic crm_acc_s crm_decode(input logic [4:0] mode,
                                          input logic [3:0] field);
    crm_acc_s a;
    a.kind = ACC_NONE;
    a.idx = 3'h0;
    if (mode[3:0] == MODE_CMP_LO) begin
      if (field == PORT_B_FIELD) begin
        a.kind = ACC_CMP;
      end
    end else if (mode[3:0] == MODE_XCHG_LO) begin
      a.kind = ACC_XCHG;
      a.idx = IDX_XCHG;
    end else if (mode[3:0] >= MODE_IDX_LOW) begin
      a.kind = mode[4] ? ACC_WRITE : ACC_READ;
      a.idx = 3'(MODE_IDX_TOP - mode[3:0]);
    end
    return a;
  endfunction

  // port transfer decode
  logic is_port;
  logic [2:0] port;
  crm_acc_s acc;
  logic bus_wr;
  logic bus_rd;

  // only the 005h..009h group reaches control registers; data stays on fr path
  assign is_port = i_instr_valid && i_instr[11:4] == OP_PORT_HI
                   && i_instr[3:0] >= PORT_FIRST
                   && i_instr[3:0] <= PORT_LAST;
  assign port = 3'(i_instr[3:0] - PORT_FIRST);
  assign acc = crm_decode(state_reg.mode, i_instr[3:0]);
  // bus writes wait for a cycle without an instruction so W has one writer
  assign bus_wr = i_axi.awvalid && i_axi.wvalid && !state_reg.bvalid
                  && !i_instr_valid;
  assign bus_rd = i_axi.arvalid && !state_reg.rvalid;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [7:0] raddr;
    logic [7:0] waddr;
    logic [7:0] roff;
    raddr = i_axi.araddr;
    waddr = i_axi.awaddr;
    roff = raddr - ADDR_CTRL_BASE;
    state_next = state_reg;
    state_next.exec = 1'b0;
    if (i_instr_valid) begin
      if (i_instr == OP_OPTION_W) begin
        state_next.option = state_reg.w;
        state_next.exec = 1'b1;
      end else if (i_instr == OP_MODE_W) begin
        state_next.mode = state_reg.w[4:0] & MODE_MASK;
        state_next.exec = 1'b1;
      end else if (i_instr[11:4] == OP_MODE_LIT_HI) begin
        state_next.mode[3:0] = i_instr[3:0];
        state_next.exec = 1'b1;
      end else if (is_port) begin
        state_next.exec = 1'b1;
        case (acc.kind)
          ACC_WRITE: begin
            state_next.ctrl[port][acc.idx] = state_reg.w;
          end
          ACC_READ: begin
            state_next.w = state_reg.ctrl[port][acc.idx];
          end
          ACC_XCHG: begin
            state_next.w = state_reg.ctrl[port][acc.idx];
            state_next.ctrl[port][acc.idx] = state_reg.w;
          end
          ACC_CMP: begin
            state_next.w = state_reg.cmp;
            state_next.cmp = state_reg.w;
          end
          default: begin
          end
        endcase
      end
    end
    // write channel
    if (state_reg.bvalid && i_axi.bready) begin
      state_next.bvalid = 1'b0;
    end
    if (bus_wr) begin
      state_next.bvalid = 1'b1;
      state_next.bresp = RESP_OKAY;
      if (waddr == ADDR_W) begin
        if (i_axi.wstrb[0]) begin
          state_next.w = i_axi.wdata[7:0];
        end
      end else if (waddr == ADDR_MODE) begin
        if (i_axi.wstrb[0]) begin
          state_next.mode = i_axi.wdata[4:0] & MODE_MASK;
        end
      end else if (waddr != ADDR_OPTION && waddr != ADDR_CMP) begin
        state_next.bresp = RESP_SLVERR;
      end
    end
    // read channel
    if (state_reg.rvalid && i_axi.rready) begin
      state_next.rvalid = 1'b0;
    end
    if (bus_rd) begin
      state_next.rvalid = 1'b1;
      state_next.rresp = RESP_OKAY;
      state_next.rdata = 32'h0;
      if (raddr == ADDR_W) begin
        state_next.rdata[7:0] = state_reg.w;
      end else if (raddr == ADDR_MODE) begin
        state_next.rdata[4:0] = state_reg.mode;
      end else if (raddr == ADDR_OPTION) begin
        state_next.rdata[7:0] = state_reg.option;
      end else if (raddr == ADDR_CMP) begin
        state_next.rdata[7:0] = state_reg.cmp;
      end else if (raddr >= ADDR_CTRL_BASE && roff[7:5] < 3'(NUM_PORTS)
                   && roff[4:2] < 3'(NUM_CTRL) && raddr[1:0] == 2'b00) begin
        state_next.rdata[7:0] = state_reg.ctrl[roff[7:5]][roff[4:2]];
      end else begin
        state_next.rresp = RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_reg <= '0;
      state_reg.w <= RST_W;
      state_reg.mode <= RST_MODE;
      state_reg.option <= RST_OPTION;
      state_reg.cmp <= RST_CMP;
      state_reg.ctrl <= {(NUM_PORTS * NUM_CTRL){RST_CTRL}};
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign o_w = state_reg.w;
  assign o_mode = state_reg.mode;
  assign o_option = state_reg.option;
  assign o_cmp_ctrl = state_reg.cmp;
  assign o_port_ctrl = state_reg.ctrl;
  assign o_exec = state_reg.exec;
  assign o_axi.awready = bus_wr;
  assign o_axi.wready = bus_wr;
  assign o_axi.bvalid = state_reg.bvalid;
  assign o_axi.bresp = state_reg.bresp;
  assign o_axi.arready = bus_rd;
  assign o_axi.rvalid = state_reg.rvalid;
  assign o_axi.rdata = state_reg.rdata;
  assign o_axi.rresp = state_reg.rresp;

  ////////////////////////////////////////////////////////////////////////////
  chk_option_load: assert property (@(posedge i_clk) disable iff (i_reset)
    i_instr_valid && i_instr == OP_OPTION_W
    |=> o_option == $past(o_w) && o_w == $past(o_w))
    else $error("option load wrong");

  chk_option_hold: assert property (@(posedge i_clk) disable iff (i_reset)
    !(i_instr_valid && i_instr == OP_OPTION_W) |=> $stable(o_option))
    else $error("option changed without its opcode");

  chk_port_write: assert property (@(posedge i_clk) disable iff (i_reset)
    is_port && acc.kind == ACC_WRITE
    |=> o_port_ctrl[$past(port)][$past(acc.idx)] == $past(o_w) && o_exec)
    else $error("port control write lost");

  chk_port_xchg: assert property (@(posedge i_clk) disable iff (i_reset)
    is_port && acc.kind == ACC_XCHG
    |=> o_w == $past(o_port_ctrl[port][IDX_XCHG])
        && o_port_ctrl[$past(port)][IDX_XCHG] == $past(o_w))
    else $error("port exchange wrong");

  chk_w_source: assert property (@(posedge i_clk) disable iff (i_reset)
    !(is_port && acc.kind inside {ACC_READ, ACC_XCHG, ACC_CMP}) && !bus_wr
    |=> $stable(o_w))
    else $error("W changed by other path");

  chk_dir_write: assert property (@(posedge i_clk) disable iff (i_reset)
    is_port && o_mode == MODE_DIR_WRITE
    |=> o_port_ctrl[$past(port)][IDX_DIR] == $past(o_w))
    else $error("direction write wrong");

  chk_cmp_select: assert property (@(posedge i_clk) disable iff (i_reset)
    is_port && o_mode[3:0] == MODE_CMP_LO
    |=> $stable(o_port_ctrl)
        && (($past(i_instr[3:0]) == PORT_B_FIELD) ? o_cmp_ctrl == $past(o_w)
                                                  : $stable(o_cmp_ctrl)))
    else $error("comparator select wrong");

  chk_cmp_xchg: assert property (@(posedge i_clk) disable iff (i_reset)
    is_port && acc.kind == ACC_CMP
    |=> o_cmp_ctrl == $past(o_w) && o_w == $past(o_cmp_ctrl))
    else $error("comparator exchange wrong");

  chk_mode_load: assert property (@(posedge i_clk) disable iff (i_reset)
    i_instr_valid && i_instr == OP_MODE_W
    |=> o_mode == ($past(o_w[4:0]) & MODE_MASK) && $stable(o_w))
    else $error("mode load wrong");

  chk_read_keeps: assert property (@(posedge i_clk) disable iff (i_reset)
    is_port && acc.kind == ACC_READ
    |=> o_w == $past(o_port_ctrl[port][acc.idx]) && $stable(o_port_ctrl))
    else $error("read access wrong");

endmodule // crm_exec
`default_nettype wire

/* File: testbench/crm_fetch_model.sv */
`timescale 1ns/1ps
`default_nettype none
module crm_fetch_model
  import crm_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // bench request
  input wire logic i_go,
  input wire logic [11:0] i_op,
  // fetch stream
  output logic o_valid,
  output logic [11:0] o_instr
);
  // idle word flips so a stale opcode never looks valid by accident
  always_ff @(posedge i_clk) begin
    o_valid <= i_go && !i_reset;
    o_instr <= i_go ? i_op : ~o_instr;
  end
endmodule // crm_fetch_model
`default_nettype wire

/* File: testbench/control_register_move_exec_test.sv */
`timescale 1ns/1ps
`default_nettype none
module control_register_move_exec_test
  import crm_pkg::*;
;
  logic i_clk, i_reset, go, vld, ex;
  logic [11:0] op, ins;
  crm_axil_req_s rq;
  crm_axil_rsp_s rs;
  logic [7:0] w, opt, cmp;
  logic [4:0] md;
  crm_ctrl_t pc;
  int n_mismatch = 0;
  int n_tests = 0;
  logic [31:0] d;
  logic [1:0] r;
  ////////////////////////////////////////////////////////////////////////
  crm_fetch_model fm (.i_clk(i_clk), .i_reset(i_reset), .i_go(go),
    .i_op(op), .o_valid(vld), .o_instr(ins));
  crm_exec #(.MODE_W(5)) dut (.i_clk(i_clk), .i_reset(i_reset),
    .i_instr_valid(vld), .i_instr(ins), .i_axi(rq), .o_axi(rs), .o_w(w),
    .o_mode(md), .o_option(opt), .o_cmp_ctrl(cmp), .o_port_ctrl(pc),
    .o_exec(ex));
  ////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen %h expected %h", $time, s, e);
    end
  endtask
  // ready is combinational: looked at on the falling edge where it has
  // settled, the transfer then happens at the next rising edge
  // bready and rready stay high for the whole run
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int k;
    int j;
    rq.awvalid <= 1'b1;
    rq.wvalid <= 1'b1;
    rq.awaddr <= a;
    rq.wdata <= v;
    rq.wstrb <= 4'hf;
    @(negedge i_clk);
    for (k = 0; k < 50 && !(rs.awready === 1'b1 && rs.wready === 1'b1);
         k++) begin
      @(negedge i_clk);
    end
    @(posedge i_clk);
    rq.awvalid <= 1'b0;
    rq.wvalid <= 1'b0;
    @(negedge i_clk);
    for (j = 0; j < 50 && rs.bvalid !== 1'b1; j++) begin
      @(negedge i_clk);
    end
    if (k == 50 || j == 50) begin
      n_mismatch++;
    end
    r = rs.bresp;
    @(posedge i_clk);
  endtask
  task automatic rd(input logic [7:0] a);
    int k;
    int j;
    rq.arvalid <= 1'b1;
    rq.araddr <= a;
    @(negedge i_clk);
    for (k = 0; k < 50 && rs.arready !== 1'b1; k++) begin
      @(negedge i_clk);
    end
    @(posedge i_clk);
    rq.arvalid <= 1'b0;
    @(negedge i_clk);
    for (j = 0; j < 50 && rs.rvalid !== 1'b1; j++) begin
      @(negedge i_clk);
    end
    if (k == 50 || j == 50) begin
      n_mismatch++;
    end
    d = rs.rdata;
    r = rs.rresp;
    @(posedge i_clk);
  endtask
  task automatic exec(input logic [11:0] o, input logic e);
    go <= 1'b1;
    op <= o;
    @(posedge i_clk);
    go <= 1'b0;
    @(posedge i_clk);
    @(negedge i_clk);
    chk({31'h0, ex}, {31'h0, e});
    @(posedge i_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  initial begin
    repeat (20000) @(posedge i_clk);
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    i_reset = 1'b1;
    go = 1'b0;
    op = 12'h000;
    rq = '{bready: 1'b1, rready: 1'b1, default: '0};
    repeat (4) @(posedge i_clk);
    i_reset <= 1'b0;
    @(posedge i_clk);
    rd(ADDR_OPTION);
    chk(d, 32'h0000_00ff);
    rd(ADDR_CMP);
    chk(d, 32'h0000_00ff);
    rd(8'h3c);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    wr(ADDR_CTRL_BASE, 32'h0000_0055);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    chk({24'h0, pc[0][IDX_DIR]}, 32'h0000_00ff);
    $display("test reset done");
    wr(ADDR_W, 32'h0000_003f);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
    exec(OP_OPTION_W, 1'b1);
    chk({24'h0, opt}, 32'h0000_003f);
    chk({24'h0, w}, 32'h0000_003f);
    $display("test option done");
    wr(ADDR_W, 32'h0000_00ff);
    exec(OP_MODE_W, 1'b1);
    chk({27'h0, md}, {27'h0, MODE_DIR_WRITE});
    chk({24'h0, w}, 32'h0000_00ff);
    for (int p = 0; p < NUM_PORTS; p++) begin
      wr(ADDR_W, 32'(8'h13 + 8'(p * 16)));
      exec({OP_PORT_HI, PORT_FIRST + 4'(p)}, 1'b1);
      chk({24'h0, pc[p][IDX_DIR]}, 32'(8'h13 + 8'(p * 16)));
      chk({24'h0, pc[p][1]}, 32'h0000_00ff);
      chk({24'h0, w}, 32'(8'h13 + 8'(p * 16)));
    end
    $display("test direction done");
    wr(ADDR_MODE, 32'h0000_000f);
    wr(ADDR_W, 32'h0000_0000);
    exec({OP_PORT_HI, PORT_B_FIELD}, 1'b1);
    chk({24'h0, w}, 32'h0000_0023);
    chk({24'h0, pc[1][IDX_DIR]}, 32'h0000_0023);
    $display("test read done");
    exec({OP_MODE_LIT_HI, MODE_CMP_LO}, 1'b1);
    chk({27'h0, md}, 32'h0000_0008);
    wr(ADDR_W, 32'h0000_0000);
    exec({OP_PORT_HI, PORT_FIRST}, 1'b1);
    chk({24'h0, cmp}, 32'h0000_00ff);
    exec({OP_PORT_HI, PORT_B_FIELD}, 1'b1);
    chk({24'h0, cmp}, 32'h0000_0000);
    chk({24'h0, w}, 32'h0000_00ff);
    exec(12'h00a, 1'b0);
    chk({24'h0, w}, 32'h0000_00ff);
    $display("test comparator done");
    wr(ADDR_MODE, 32'h0000_0019);
    wr(ADDR_W, 32'h0000_005a);
    exec({OP_PORT_HI, 4'h7}, 1'b1);
    chk({24'h0, w}, 32'h0000_00ff);
    chk({24'h0, pc[2][IDX_XCHG]}, 32'h0000_005a);
    rd(8'h98);
    chk(d, 32'h0000_005a);
    exec({OP_PORT_HI, 4'h7}, 1'b1);
    chk({24'h0, w}, 32'h0000_005a);
    chk({24'h0, pc[2][IDX_XCHG]}, 32'h0000_00ff);
    exec({OP_MODE_LIT_HI, MODE_CMP_LO}, 1'b1);
    chk({27'h0, md}, 32'h0000_0018);
    exec({OP_PORT_HI, PORT_B_FIELD}, 1'b1);
    chk({24'h0, w}, 32'h0000_0000);
    chk({24'h0, cmp}, 32'h0000_005a);
    $display("test exchange done");
    report_and_stop();
  end
endmodule // control_register_move_exec_test
`default_nettype wire
